// File: src/clock_status_pkg.sv
// Constants, field layouts and carrier types for the clock status and unlock block
`default_nettype none

package clock_status_pkg;
    localparam logic [9:0] STATUS_OFFSET = 10'h014;
    localparam logic [9:0] UNLOCK_OFFSET = 10'h018;
    localparam logic [9:0] OSC_CTRL_OFFSET = 10'h024;
    localparam logic [7:0] UNLOCK_KEY = 8'hAA;
    localparam logic [31:0] LOCK_ON_WORD = 32'h5A5A_5A5A;
    localparam logic [31:0] LOCK_OFF_WORD = 32'hA5AA_5A55;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam int KEY_MSB = 31;
    localparam int KEY_LSB = 24;
    localparam int ADDR_MSB = 9;
    localparam int OSC_EN_BIT = 16;
    localparam int STARTUP_MSB = 11;
    localparam int STARTUP_LSB = 8;
    localparam int AUTO_GAIN_BIT = 3;
    localparam int GAIN_MSB = 2;
    localparam int GAIN_LSB = 1;
    localparam int MODE_BIT = 0;
    localparam int BACKUP_VALID_BIT = 30;
    localparam int PLL_LOST_BIT = 18;
    localparam int PLL_LOCK_BIT = 17;
    localparam int BACKUP_READY_BIT = 16;
    localparam int FLL_REF_STOP_BIT = 15;
    localparam int FLL_SYNC_BIT = 14;
    localparam int FLL_LOST_LSB = 11;
    localparam int FLL_LOCK_LSB = 8;
    localparam int BROWNOUT_BIT = 7;
    localparam int SM_LOW_BIT = 6;
    localparam int VREG_BIT = 5;
    localparam int MAIN_RDY_BIT = 1;
    localparam int SLOW_RDY_BIT = 0;
    localparam int STARTUP_WIDTH = 20;

    // Analog and neighbouring-block conditions sampled into the status word
    typedef struct packed {
        logic pll_lock_lost_flag;
        logic pll_locked_flag;
        logic backup_interface_ready;
        logic backup_contents_valid;
        logic fll_reference_stopped;
        logic fll_sync_ready;
        logic [2:0] fll_lock_lost;
        logic [2:0] fll_locked;
        logic brownout_flag;
        logic supply_monitor_enabled;
        logic supply_monitor_below;
        logic regulator_ok_flag;
        logic slow_oscillator_ready;
    } status_in_t;

    // Main oscillator settings driven to the analog cell
    typedef struct packed {
        logic oscillator_enable_bit;
        logic [3:0] startup;
        logic auto_gain_test_bit;
        logic [1:0] gain;
        logic crystal_mode;
    } osc_ctrl_t;
endpackage : clock_status_pkg

`default_nettype wire

// File: src/clock_status_unlock_osc_ctrl.sv
// Status word, keyed write protection and main oscillator control
`default_nettype none

module clock_status_unlock_osc_ctrl #(
    parameter int STARTUP_SHIFT = 4
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic bus_sel,
    input wire logic bus_write,
    input wire logic [9:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    input wire clock_status_pkg::status_in_t status_in,
    output clock_status_pkg::osc_ctrl_t osc_ctrl,
    output logic main_oscillator_ready,
    output logic global_lock_on,
    output logic protect_violation
);
    import clock_status_pkg::*;

    typedef enum logic [1:0] {OSC_OFF, OSC_STARTING, OSC_READY} osc_state_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic armed;
        logic [9:0] armed_addr;
        logic lock_on;
        logic violation;
        osc_ctrl_t ctrl;
        osc_state_t osc_state;
        logic [STARTUP_WIDTH-1:0] count;
        logic pll_lost_seen;
        logic ref_stop_seen;
        logic [2:0] fll_lost_seen;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [31:0] status_word;
    logic unlock_hit;
    logic write_granted;
    logic [STARTUP_WIDTH-1:0] startup_cycles;

    // ----------------------------------------------------------------
    // Status word assembly
    // ----------------------------------------------------------------
    always_comb begin
        status_word = RESET_WORD;
        status_word[BACKUP_VALID_BIT] = status_in.backup_contents_valid;
        status_word[PLL_LOST_BIT] = state_reg.pll_lost_seen;
        status_word[PLL_LOCK_BIT] = status_in.pll_locked_flag;
        status_word[BACKUP_READY_BIT] = status_in.backup_interface_ready;
        status_word[FLL_REF_STOP_BIT] = state_reg.ref_stop_seen;
        status_word[FLL_SYNC_BIT] = status_in.fll_sync_ready;
        status_word[FLL_LOST_LSB +: 3] = state_reg.fll_lost_seen;
        status_word[FLL_LOCK_LSB +: 3] = status_in.fll_locked;
        status_word[BROWNOUT_BIT] = status_in.brownout_flag;
        // supply monitor gated by its enable
        status_word[SM_LOW_BIT] = status_in.supply_monitor_enabled & status_in.supply_monitor_below;
        status_word[VREG_BIT] = status_in.regulator_ok_flag;
        status_word[MAIN_RDY_BIT] = (state_reg.osc_state == OSC_READY);
        status_word[SLOW_RDY_BIT] = status_in.slow_oscillator_ready;
    end

    // start-up count is the field shifted left by STARTUP_SHIFT, plus one
    assign startup_cycles = STARTUP_WIDTH'(({16'h0000, state_reg.ctrl.startup} << STARTUP_SHIFT)) +
        STARTUP_WIDTH'(1);

    assign unlock_hit = bus_wdata[KEY_MSB:KEY_LSB] == UNLOCK_KEY;

    // grant while the lock is off, or for the access right after a matching unlock
    assign write_granted = !state_reg.lock_on || (state_reg.armed && state_reg.armed_addr == bus_addr);

    always_comb begin
        state_next = state_reg;
        state_next.violation = 1'b0;
        // Sticky lost flags: hardware events only, cleared by reset
        // latch PLL lock loss
        state_next.pll_lost_seen = state_reg.pll_lost_seen | status_in.pll_lock_lost_flag;
        state_next.ref_stop_seen = state_reg.ref_stop_seen | status_in.fll_reference_stopped;
        state_next.fll_lost_seen = state_reg.fll_lost_seen | status_in.fll_lock_lost;
        if (bus_sel) begin
            // Any access consumes a pending unlock
            state_next.armed = 1'b0;
            state_next.rdata = RESET_WORD;
            if (!bus_write) begin
                case (bus_addr)
                    STATUS_OFFSET: state_next.rdata = status_word;
                    OSC_CTRL_OFFSET: state_next.rdata = {15'h0000, state_reg.ctrl.oscillator_enable_bit, 4'h0,
                        state_reg.ctrl.startup, 4'h0, state_reg.ctrl.auto_gain_test_bit,
                        state_reg.ctrl.gain, state_reg.ctrl.crystal_mode};
                    default: state_next.rdata = RESET_WORD;
                endcase
            end else if (bus_addr == UNLOCK_OFFSET && state_reg.armed && state_reg.armed_addr == UNLOCK_OFFSET &&
                (bus_wdata == LOCK_ON_WORD || bus_wdata == LOCK_OFF_WORD)) begin
                state_next.lock_on = (bus_wdata == LOCK_ON_WORD);
            end else if (bus_addr == UNLOCK_OFFSET) begin
                state_next.armed = unlock_hit;
                state_next.armed_addr = bus_wdata[ADDR_MSB:0];
            end else if (bus_addr == OSC_CTRL_OFFSET) begin
                if (write_granted) begin
                    state_next.ctrl.oscillator_enable_bit = bus_wdata[OSC_EN_BIT];
                    state_next.ctrl.startup = bus_wdata[STARTUP_MSB:STARTUP_LSB];
                    state_next.ctrl.auto_gain_test_bit = bus_wdata[AUTO_GAIN_BIT];
                    state_next.ctrl.gain = bus_wdata[GAIN_MSB:GAIN_LSB];
                    state_next.ctrl.crystal_mode = bus_wdata[MODE_BIT];
                end else begin
                    state_next.violation = 1'b1;
                end
            end
        end
        case (state_reg.osc_state)
            OSC_OFF: begin
                state_next.count = '0;
                if (state_reg.ctrl.oscillator_enable_bit) begin
                    state_next.osc_state = OSC_STARTING;
                end
            end
            OSC_STARTING: begin
                state_next.count = state_reg.count + STARTUP_WIDTH'(1);
                if (!state_reg.ctrl.oscillator_enable_bit) begin
                    state_next.osc_state = OSC_OFF;
                end else if (state_reg.count + STARTUP_WIDTH'(1) >= startup_cycles) begin
                    state_next.osc_state = OSC_READY;
                end
            end
            OSC_READY: begin
                if (!state_reg.ctrl.oscillator_enable_bit) begin
                    state_next.osc_state = OSC_OFF;
                end
            end
            default: state_next.osc_state = OSC_OFF;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.osc_state <= OSC_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus_rdata = state_reg.rdata;
    assign osc_ctrl = state_reg.ctrl;
    assign main_oscillator_ready = (state_reg.osc_state == OSC_READY);
    assign global_lock_on = state_reg.lock_on;
    assign protect_violation = state_reg.violation;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_status_read;
        bus_sel && !bus_write && bus_addr == STATUS_OFFSET;
    endsequence

    property p_status_valid;
        @(posedge core_clk) disable iff (reset)
        s_status_read |=> bus_rdata[BACKUP_VALID_BIT] == $past(status_in.backup_contents_valid);
    endproperty
    a_status_valid: assert property (p_status_valid) else $error("backup valid bit wrong");

    property p_pll_lost;
        @(posedge core_clk) disable iff (reset)
        status_in.pll_lock_lost_flag |=> status_word[PLL_LOST_BIT];
    endproperty
    a_pll_lost: assert property (p_pll_lost) else $error("pll lost not latched");

    property p_sm_gate;
        @(posedge core_clk) disable iff (reset)
        !status_in.supply_monitor_enabled |-> !status_word[SM_LOW_BIT];
    endproperty
    a_sm_gate: assert property (p_sm_gate) else $error("monitor flag while disabled");

    property p_lock_reset;
        @(posedge core_clk) $fell(reset) |-> !global_lock_on;
    endproperty
    a_lock_reset: assert property (p_lock_reset) else $error("lock on after reset");

    sequence s_arm_self;
        bus_sel && bus_write && bus_addr == UNLOCK_OFFSET && bus_wdata[KEY_MSB:KEY_LSB] == UNLOCK_KEY &&
            bus_wdata[ADDR_MSB:0] == UNLOCK_OFFSET;
    endsequence
    property p_lock_on;
        @(posedge core_clk) disable iff (reset)
        s_arm_self ##1 (bus_sel && bus_write && bus_addr == UNLOCK_OFFSET && bus_wdata == LOCK_ON_WORD) |=>
            global_lock_on;
    endproperty
    a_lock_on: assert property (p_lock_on) else $error("lock not switched on");

    property p_lock_off;
        @(posedge core_clk) disable iff (reset)
        s_arm_self ##1 (bus_sel && bus_write && bus_addr == UNLOCK_OFFSET && bus_wdata == LOCK_OFF_WORD) |=>
            !global_lock_on;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock not switched off");

    property p_protect;
        @(posedge core_clk) disable iff (reset)
        global_lock_on && !state_reg.armed && bus_sel && bus_write && bus_addr == OSC_CTRL_OFFSET |=>
            $stable(osc_ctrl) && protect_violation;
    endproperty
    a_protect: assert property (p_protect) else $error("protected write accepted");

    property p_enable;
        @(posedge core_clk) disable iff (reset)
        !global_lock_on && bus_sel && bus_write && bus_addr == OSC_CTRL_OFFSET |=>
            osc_ctrl.oscillator_enable_bit == $past(bus_wdata[OSC_EN_BIT]);
    endproperty
    a_enable: assert property (p_enable) else $error("enable bit not taken");

    property p_ready_off;
        @(posedge core_clk) disable iff (reset)
        !osc_ctrl.oscillator_enable_bit ##1 !osc_ctrl.oscillator_enable_bit |-> !main_oscillator_ready;
    endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready while disabled");

    property p_pll_locked;
        @(posedge core_clk) disable iff (reset)
        s_status_read |=> bus_rdata[PLL_LOCK_BIT] == $past(status_in.pll_locked_flag);
    endproperty
    a_pll_locked: assert property (p_pll_locked) else $error("pll locked bit wrong");

    property p_backup_ready;
        @(posedge core_clk) disable iff (reset)
        s_status_read |=> bus_rdata[BACKUP_READY_BIT] == $past(status_in.backup_interface_ready);
    endproperty
    a_backup_ready: assert property (p_backup_ready) else $error("backup ready bit wrong");

    property p_ref_stop;
        @(posedge core_clk) disable iff (reset)
        status_in.fll_reference_stopped |=> status_word[FLL_REF_STOP_BIT];
    endproperty
    a_ref_stop: assert property (p_ref_stop) else $error("reference stop not latched");

    property p_fll_sync;
        @(posedge core_clk) disable iff (reset)
        s_status_read |=> bus_rdata[FLL_SYNC_BIT] == $past(status_in.fll_sync_ready);
    endproperty
    a_fll_sync: assert property (p_fll_sync) else $error("fll sync bit wrong");

    property p_fll_lost;
        @(posedge core_clk) disable iff (reset)
        status_in.fll_lock_lost != 3'h0 |=>
            (status_word[FLL_LOST_LSB +: 3] & $past(status_in.fll_lock_lost)) == $past(status_in.fll_lock_lost);
    endproperty
    a_fll_lost: assert property (p_fll_lost) else $error("fll lock loss not latched");

    property p_fll_locked;
        @(posedge core_clk) disable iff (reset)
        s_status_read |=> bus_rdata[FLL_LOCK_LSB +: 3] == $past(status_in.fll_locked);
    endproperty
    a_fll_locked: assert property (p_fll_locked) else $error("fll lock levels wrong");

    property p_brownout;
        @(posedge core_clk) disable iff (reset)
        s_status_read |=> bus_rdata[BROWNOUT_BIT] == $past(status_in.brownout_flag);
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out bit wrong");

    property p_regulator;
        @(posedge core_clk) disable iff (reset)
        s_status_read |=> bus_rdata[VREG_BIT] == $past(status_in.regulator_ok_flag);
    endproperty
    a_regulator: assert property (p_regulator) else $error("regulator bit wrong");

    property p_ready_flags;
        @(posedge core_clk) disable iff (reset)
        s_status_read |=> bus_rdata[MAIN_RDY_BIT] == $past(main_oscillator_ready) &&
            bus_rdata[SLOW_RDY_BIT] == $past(status_in.slow_oscillator_ready);
    endproperty
    a_ready_flags: assert property (p_ready_flags) else $error("oscillator ready bits wrong");

    // A keyed unlock write always arms, whatever the unused bits hold
    property p_arm;
        @(posedge core_clk) disable iff (reset)
        bus_sel && bus_write && bus_addr == UNLOCK_OFFSET && bus_wdata[KEY_MSB:KEY_LSB] == UNLOCK_KEY |=>
            state_reg.armed && state_reg.armed_addr == $past(bus_wdata[ADDR_MSB:0]);
    endproperty
    a_arm: assert property (p_arm) else $error("unlock not armed");

    property p_one_shot;
        @(posedge core_clk) disable iff (reset)
        bus_sel && !(bus_write && bus_addr == UNLOCK_OFFSET) |=> !state_reg.armed;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("unlock survived an access");

    property p_fields;
        @(posedge core_clk) disable iff (reset)
        !global_lock_on && bus_sel && bus_write && bus_addr == OSC_CTRL_OFFSET |=>
            osc_ctrl.startup == $past(bus_wdata[STARTUP_MSB:STARTUP_LSB]) &&
            osc_ctrl.auto_gain_test_bit == $past(bus_wdata[AUTO_GAIN_BIT]) &&
            osc_ctrl.gain == $past(bus_wdata[GAIN_MSB:GAIN_LSB]) &&
            osc_ctrl.crystal_mode == $past(bus_wdata[MODE_BIT]);
    endproperty
    a_fields: assert property (p_fields) else $error("control fields not taken");

    // Ready may only rise once the selected start-up count has run out
    property p_start_count;
        @(posedge core_clk) disable iff (reset)
        $rose(main_oscillator_ready) |-> state_reg.count >= $past(startup_cycles);
    endproperty
    a_start_count: assert property (p_start_count) else $error("ready before start-up count");
endmodule : clock_status_unlock_osc_ctrl

`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the status word, write protection and oscillator control
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import clock_status_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int SH = 1;
    localparam logic [31:0] CMASK = 32'h0001_0F0F;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic bus_sel = 1'b0;
    logic bus_write = 1'b0;
    logic [9:0] bus_addr = 10'h000;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic [31:0] bus_rdata;
    status_in_t status_in = '0;
    status_in_t sv;
    osc_ctrl_t osc_ctrl;
    logic main_oscillator_ready;
    logic global_lock_on;
    logic protect_violation;
    logic [31:0] rnd = 32'h0000_004C;
    logic [31:0] ctrl_exp = 32'h0000_0000;
    logic [4:0] sticky = 5'h00;
    int err_total = 0;
    int n_compared = 0;
    int pv_cnt = 0;
    int p0;
    int cnt;
    int n;

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    clock_status_unlock_osc_ctrl #(.STARTUP_SHIFT(SH)) dut_u (.core_clk(core_clk), .reset(reset),
        .bus_sel(bus_sel), .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .status_in(status_in), .osc_ctrl(osc_ctrl),
        .main_oscillator_ready(main_oscillator_ready), .global_lock_on(global_lock_on),
        .protect_violation(protect_violation));

    // Pulses are counted so their exact cycle does not matter
    always @(posedge core_clk) begin
        if (protect_violation === 1'b1) pv_cnt <= pv_cnt + 1;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [31:0] stat_exp(input status_in_t s, input logic [4:0] st, input logic rdy);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[30] = s.backup_contents_valid;
        v[18] = st[4];
        v[17] = s.pll_locked_flag;
        v[16] = s.backup_interface_ready;
        v[15] = st[3];
        v[14] = s.fll_sync_ready;
        v[13:11] = st[2:0];
        v[10:8] = s.fll_locked;
        v[7] = s.brownout_flag;
        v[6] = s.supply_monitor_enabled & s.supply_monitor_below;
        v[5] = s.regulator_ok_flag;
        v[1] = rdy;
        v[0] = s.slow_oscillator_ready;
        return v;
    endfunction : stat_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic acc(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_sel <= 1'b1;
        bus_write <= wr;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge core_clk);
        bus_sel <= 1'b0;
        #1;
    endtask : acc

    task automatic summarize();
        if (err_total == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        check({20'h0_0000, osc_ctrl, main_oscillator_ready, global_lock_on, protect_violation}, 32'h0);
        for (int i = 0; i < 12; i++) begin
            @(posedge core_clk);
            sv = (i == 0) ? status_in_t'(17'h0_0000) : status_in_t'(rnd[16:0]);
            rnd = lfsr(rnd);
            status_in <= sv;
            sticky = sticky | {sv.pll_lock_lost_flag, sv.fll_reference_stopped, sv.fll_lock_lost};
            acc(1'b0, STATUS_OFFSET, 32'h0);
            check(bus_rdata, stat_exp(sv, sticky, 1'b0));
        end
        acc(1'b1, STATUS_OFFSET, rnd);
        acc(1'b0, STATUS_OFFSET, 32'h0);
        check(bus_rdata, stat_exp(sv, sticky, 1'b0));
        acc(1'b0, UNLOCK_OFFSET, 32'h0);
        check(bus_rdata, 32'h0);
        acc(1'b0, 10'h3FC, 32'h0);
        check(bus_rdata, 32'h0);
        for (int i = 0; i < 6; i++) begin
            ctrl_exp = (i == 0) ? CMASK : (i == 1) ? 32'h0000_0000 : rnd & CMASK;
            acc(1'b1, OSC_CTRL_OFFSET, (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'hFFFE_F0F0 : rnd);
            rnd = lfsr(rnd);
            acc(1'b0, OSC_CTRL_OFFSET, 32'h0);
            check(bus_rdata, ctrl_exp);
            check({23'h0, osc_ctrl}, {23'h0, ctrl_exp[16], ctrl_exp[11:8], ctrl_exp[3:0]});
        end
        @(posedge core_clk);
        status_in <= '0;
        sv = '0;
        for (int j = 0; j < 3; j++) begin
            n = ((j * 7) << SH) + 1;
            ctrl_exp = {15'h0, 1'b1, 4'h0, 4'(j * 7), 8'h01};
            acc(1'b1, OSC_CTRL_OFFSET, 32'h0);
            repeat (2) @(posedge core_clk);
            #1;
            check({31'h0, main_oscillator_ready}, 32'h0);
            acc(1'b1, OSC_CTRL_OFFSET, {15'h0, 1'b1, 4'h0, 4'(j * 7), 8'h01});
            cnt = 0;
            while (main_oscillator_ready !== 1'b1 && cnt < 200) begin
                @(posedge core_clk);
                #1;
                cnt++;
            end
            check({31'h0, cnt >= n && cnt <= n + 3}, 32'h1);
            acc(1'b0, STATUS_OFFSET, 32'h0);
            check(bus_rdata, stat_exp(sv, sticky, 1'b1));
        end
        // unlock naming itself, then lock on
        acc(1'b1, UNLOCK_OFFSET, {UNLOCK_KEY, 14'h0, UNLOCK_OFFSET});
        acc(1'b1, UNLOCK_OFFSET, LOCK_ON_WORD);
        @(posedge core_clk);
        #1;
        check({31'h0, global_lock_on}, 32'h1);
        for (int k = 0; k < 6; k++) begin
            p0 = pv_cnt;
            // key and offset first, target next
            if (k > 0) acc(1'b1, UNLOCK_OFFSET, {(k == 1) ? 8'h55 : UNLOCK_KEY, (k == 4) ? 14'h3FFF : 14'h0,
                (k == 2) ? STATUS_OFFSET : OSC_CTRL_OFFSET});
            if (k == 3) acc(1'b0, STATUS_OFFSET, 32'h0);
            acc(1'b1, OSC_CTRL_OFFSET, rnd);
            if (k >= 4) ctrl_exp = rnd & CMASK;
            rnd = lfsr(rnd);
            repeat (2) @(posedge core_clk);
            #1;
            check(32'(pv_cnt - p0), (k >= 4) ? 32'h0 : 32'h1);
            acc(1'b0, OSC_CTRL_OFFSET, 32'h0);
            check(bus_rdata, ctrl_exp);
        end
        acc(1'b1, UNLOCK_OFFSET, {UNLOCK_KEY, 14'h0, UNLOCK_OFFSET});
        acc(1'b1, UNLOCK_OFFSET, LOCK_OFF_WORD);
        @(posedge core_clk);
        #1;
        check({31'h0, global_lock_on}, 32'h0);
        acc(1'b1, OSC_CTRL_OFFSET, 32'h0000_0F06);
        acc(1'b0, OSC_CTRL_OFFSET, 32'h0);
        check(bus_rdata, 32'h0000_0F06);
        // Reset in mid-run must drop a lock that is on
        acc(1'b1, UNLOCK_OFFSET, {UNLOCK_KEY, 14'h0, UNLOCK_OFFSET});
        acc(1'b1, UNLOCK_OFFSET, LOCK_ON_WORD);
        check({31'h0, global_lock_on}, 32'h1);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        check({20'h0_0000, osc_ctrl, main_oscillator_ready, global_lock_on, protect_violation}, 32'h0);
        summarize();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
